/* hdl/cop_node.sv */
// Protocol layer of the slave node: network state, SDO server, PDO and emergency.
`timescale 1ns/1ps
module cop_node #(
  parameter logic [6:0] NODE_ID = 7'h01
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Received frames from the controller
  input wire logic rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  // Frames to the controller
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [10:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  // Object dictionary access
  output logic od_req,
  output logic od_wr,
  output logic [15:0] od_index,
  output logic [7:0] od_sub,
  output logic [31:0] od_wdata,
  input wire logic od_ack,
  input wire logic od_err,
  input wire logic [31:0] od_rdata,
  // Process data
  input wire logic [cop_pkg::NCH*32-1:0] tpdo_map,
  input wire logic [cop_pkg::NCH-1:0] tpdo_event,
  output logic rpdo_valid,
  output logic [1:0] rpdo_chan,
  output logic [63:0] rpdo_data,
  // Faults and status
  input wire logic hw_fault,
  input wire logic [15:0] fault_code,
  output cop_pkg::cop_nmt_t state,
  output logic app_reset
);
  import cop_pkg::*;

  // Identifiers of the predefined connection set for this node.
  function automatic logic [10:0] cob_of(input logic [10:0] base, input logic [1:0] ch);
    return base + {1'b0, ch, 8'h00} + {4'h0, NODE_ID}; // R21
  endfunction : cob_of

  function automatic logic [63:0] sdo_abort(input logic [23:0] mux, input logic [31:0] code);
    return {code, mux, SCS_ABT};
  endfunction : sdo_abort

  cop_nmt_t next_state;
  logic pre_op;
  logic nmt_hit;
  logic [7:0] nmt_cmd;
  logic sync_hit;
  logic sdo_hit;
  logic [2:0] ccs;
  logic is_tcfg;
  logic [1:0] tch;
  logic [NCH-1:0] rtr_hit;
  logic [NCH-1:0] rpdo_hit;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] grant;
  logic [NCH-1:0] cfg_we;
  logic [7:0] ttype [NCH];
  logic [31:0] snap [NCH];
  logic comm_clr;
  logic boot_load;
  logic emcy_load;
  logic sdo_load;
  logic found;
  logic tx_is_pdo;

  assign pre_op = (state == ST_PREOP) || (state == ST_OP); // R8
  assign comm_clr = (state == ST_RCOM); // R7
  assign app_reset = (state == ST_RAPP); // R6
  assign nmt_cmd = rx_data[7:0];
  assign nmt_hit = rx_valid && !rx_rtr && rx_id == COB_NMT
    && (rx_data[15:8] == NMT_ALL || rx_data[15:8] == {1'b0, NODE_ID})
    && (pre_op || state == ST_STOP); // R8
  // Time-stamp frames match no decoder below and are dropped without effect.
  assign sync_hit = rx_valid && !rx_rtr && rx_id == COB_SYNC && pre_op; // R9 R21
  assign sdo_hit = rx_valid && !rx_rtr && rx_id == cob_of(COB_SDO_RX, 2'h0) && pre_op; // R11
  assign ccs = rx_data[7:5];
  assign is_tcfg = rx_data[23:10] == IDX_TPDO_COMM[15:2] && rx_data[31:24] == SUB_TTYPE;
  assign tch = rx_data[9:8];
  assign tx_is_pdo = tx_id > COB_TPDO && tx_id < COB_SDO_TX;

  genvar k;
  generate
    for (k = 0; k < NCH; k++) begin : g_pdo
      assign rtr_hit[k] = rx_valid && rx_rtr && rx_id == cob_of(COB_TPDO, 2'(k))
        && state == ST_OP;
      assign rpdo_hit[k] = rx_valid && !rx_rtr && rx_id == cob_of(COB_RPDO, 2'(k))
        && state == ST_OP; // R13
      cop_tpdo u_tpdo (
        .clk(clk),
        .reset(reset),
        .op(state == ST_OP),
        .sync(sync_hit),
        .rtr(rtr_hit[k]),
        .event_in(tpdo_event[k]),
        .grant(grant[k]),
        .comm_clr(comm_clr),
        .cfg_we(cfg_we[k]),
        .cfg_type(rx_data[39:32]),
        .map_data(tpdo_map[k*32 +: 32]),
        .ttype(ttype[k]),
        .pend(pend[k]),
        .snap(snap[k])
      );
    end
  endgenerate

  // Network state.
  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (boot_load) begin
          next_state = ST_PREOP; // R2
        end
      end
      ST_RAPP: next_state = ST_RCOM; // R6
      ST_RCOM: next_state = ST_INIT; // R7
      ST_PREOP, ST_OP, ST_STOP: begin
        if (nmt_hit) begin
          case (nmt_cmd)
            NMT_START: next_state = ST_OP; // R3
            NMT_PREOP: next_state = ST_PREOP; // R4
            NMT_STOP: next_state = ST_STOP; // R5
            NMT_RNODE: next_state = ST_RAPP; // R6
            NMT_RCOMM: next_state = ST_RCOM; // R7
            default: next_state = state;
          endcase
        end
      end
      default: next_state = ST_INIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_INIT; // R1
    end else begin
      state <= next_state;
    end
  end

  // Transmit slot; one frame waits for the controller at a time.
  logic next_tx_valid;
  logic [10:0] next_tx_id;
  logic [3:0] next_tx_dlc;
  logic [63:0] next_tx_data;
  logic emcy_pend;
  logic next_emcy_pend;
  logic [15:0] emcy_code;
  logic [15:0] next_emcy_code;
  logic sdo_pend;
  logic [63:0] sdo_resp;

  always_comb begin
    next_tx_valid = tx_valid && !tx_ready;
    next_tx_id = tx_id;
    next_tx_dlc = tx_dlc;
    next_tx_data = tx_data;
    boot_load = 1'b0;
    emcy_load = 1'b0;
    sdo_load = 1'b0;
    grant = '0;
    found = 1'b0;
    if (!tx_valid) begin
      if (state == ST_INIT) begin
        boot_load = 1'b1; // R2
        next_tx_valid = 1'b1;
        next_tx_id = cob_of(COB_BOOT, 2'h0);
        next_tx_dlc = DLC_BOOT;
        next_tx_data = {56'h0, BOOT_BYTE};
      end else if (emcy_pend && pre_op) begin
        emcy_load = 1'b1; // R20
        next_tx_valid = 1'b1;
        next_tx_id = cob_of(COB_EMCY, 2'h0);
        next_tx_dlc = DLC_FULL;
        next_tx_data = {40'h0, EMCY_ERR_REG, emcy_code};
      end else if (sdo_pend) begin
        sdo_load = 1'b1;
        next_tx_valid = 1'b1;
        next_tx_id = cob_of(COB_SDO_TX, 2'h0); // R11
        next_tx_dlc = DLC_FULL;
        next_tx_data = sdo_resp;
      end else if (state == ST_OP) begin
        for (int i = 0; i < NCH; i++) begin
          if (pend[i] && !found) begin
            found = 1'b1;
            grant[i] = 1'b1; // R13
            next_tx_valid = 1'b1;
            next_tx_id = cob_of(COB_TPDO, 2'(i));
            next_tx_dlc = DLC_PDO;
            next_tx_data = {32'h0, snap[i]}; // R19
          end
        end
      end
    end
  end

  // Emergency; a fault outside pre-operational and operational is not reported.
  always_comb begin
    next_emcy_pend = emcy_pend && !emcy_load;
    next_emcy_code = emcy_code;
    if (hw_fault && pre_op) begin
      next_emcy_pend = 1'b1; // R20
      next_emcy_code = fault_code;
    end
    if (!pre_op) begin
      next_emcy_pend = 1'b0; // R8
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_valid <= 1'b0;
      tx_id <= '0;
      tx_dlc <= '0;
      tx_data <= '0;
      emcy_pend <= 1'b0;
      emcy_code <= '0;
    end else begin
      tx_valid <= next_tx_valid;
      tx_id <= next_tx_id;
      tx_dlc <= next_tx_dlc;
      tx_data <= next_tx_data;
      emcy_pend <= next_emcy_pend;
      emcy_code <= next_emcy_code;
    end
  end

  // SDO server. Every object is one word, so only expedited transfers are served.
  logic next_od_req;
  logic next_od_wr;
  logic [15:0] next_od_index;
  logic [7:0] next_od_sub;
  logic [31:0] next_od_wdata;
  logic next_sdo_pend;
  logic [63:0] next_sdo_resp;
  logic [23:0] mux;
  logic [23:0] next_mux;

  always_comb begin
    next_od_req = od_req;
    next_od_wr = od_wr;
    next_od_index = od_index;
    next_od_sub = od_sub;
    next_od_wdata = od_wdata;
    next_sdo_pend = sdo_pend && !sdo_load;
    next_sdo_resp = sdo_resp;
    next_mux = mux;
    cfg_we = '0;
    if (od_req && od_ack) begin
      next_od_req = 1'b0;
      next_sdo_pend = 1'b1;
      if (od_err) begin
        next_sdo_resp = sdo_abort(mux, AB_OD);
      end else if (od_wr) begin
        next_sdo_resp = {32'h0, mux, SCS_DL_RSP};
      end else begin
        next_sdo_resp = {od_rdata, mux, SCS_UL_RSP};
      end
    end
    if (sdo_hit) begin
      if (ccs == CCS_ABT) begin
        next_od_req = 1'b0; // R12
        next_sdo_pend = 1'b0;
      end else if (!od_req && !sdo_pend) begin
        next_mux = rx_data[31:8];
        next_sdo_pend = 1'b1;
        case (ccs)
          CCS_DL: begin
            if (!rx_data[SDO_EXP_BIT]) begin
              next_sdo_resp = sdo_abort(rx_data[31:8], AB_LEN); // R10
            end else if (is_tcfg) begin
              if (cop_tt_ok(rx_data[39:32])) begin
                cfg_we[tch] = 1'b1;
                next_sdo_resp = {32'h0, rx_data[31:8], SCS_DL_RSP};
              end else begin
                next_sdo_resp = sdo_abort(rx_data[31:8], AB_RANGE); // R17 R23
              end
            end else begin
              next_sdo_pend = 1'b0; // R12
              next_od_req = 1'b1;
              next_od_wr = 1'b1;
              next_od_index = rx_data[23:8];
              next_od_sub = rx_data[31:24];
              next_od_wdata = rx_data[63:32];
            end
          end
          CCS_UL: begin
            if (is_tcfg) begin
              next_sdo_resp = {24'h0, ttype[tch], rx_data[31:8], SCS_UL_RSP}; // R10
            end else begin
              next_sdo_pend = 1'b0; // R12
              next_od_req = 1'b1;
              next_od_wr = 1'b0;
              next_od_index = rx_data[23:8];
              next_od_sub = rx_data[31:24];
            end
          end
          default: next_sdo_resp = sdo_abort(rx_data[31:8], AB_CMD);
        endcase
      end
    end
    if (!pre_op) begin
      next_od_req = 1'b0; // R8
      next_sdo_pend = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      od_req <= 1'b0;
      od_wr <= 1'b0;
      od_index <= '0;
      od_sub <= '0;
      od_wdata <= '0;
      sdo_pend <= 1'b0;
      sdo_resp <= '0;
      mux <= '0;
    end else begin
      od_req <= next_od_req;
      od_wr <= next_od_wr;
      od_index <= next_od_index;
      od_sub <= next_od_sub;
      od_wdata <= next_od_wdata;
      sdo_pend <= next_sdo_pend;
      sdo_resp <= next_sdo_resp;
      mux <= next_mux;
    end
  end

  // Received process data; consumers get it one cycle after the frame.
  logic next_rpdo_valid;
  logic [1:0] next_rpdo_chan;
  logic [63:0] next_rpdo_data;

  always_comb begin
    next_rpdo_valid = 1'b0;
    next_rpdo_chan = rpdo_chan;
    next_rpdo_data = rpdo_data;
    for (int i = 0; i < NCH; i++) begin
      if (rpdo_hit[i]) begin
        next_rpdo_valid = 1'b1; // R13
        next_rpdo_chan = 2'(i);
        next_rpdo_data = rx_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rpdo_valid <= 1'b0;
      rpdo_chan <= '0;
      rpdo_data <= '0;
    end else begin
      rpdo_valid <= next_rpdo_valid;
      rpdo_chan <= next_rpdo_chan;
      rpdo_data <= next_rpdo_data;
    end
  end

  sequence s_app_path;
    state == ST_RAPP ##1 state == ST_RCOM ##1 state == ST_INIT;
  endsequence

  a_power_init: assert property (@(posedge clk) reset |=> state == ST_INIT) // R1
    else $error("reset did not enter initialization");
  a_boot_preop: assert property (@(posedge clk) disable iff (reset) // R2
    state == ST_INIT && !tx_valid |=> state == ST_PREOP && tx_id == cob_of(COB_BOOT, 2'h0))
    else $error("boot-up not followed by pre-operational");
  a_start_node: assert property (@(posedge clk) disable iff (reset) // R3
    nmt_hit && nmt_cmd == NMT_START |=> state == ST_OP)
    else $error("start command ignored");
  a_enter_preop: assert property (@(posedge clk) disable iff (reset) // R4
    nmt_hit && nmt_cmd == NMT_PREOP |=> state == ST_PREOP)
    else $error("pre-operational command ignored");
  a_stop_node: assert property (@(posedge clk) disable iff (reset) // R5
    nmt_hit && nmt_cmd == NMT_STOP |=> state == ST_STOP)
    else $error("stop command ignored");
  a_reset_node: assert property (@(posedge clk) disable iff (reset) // R6
    nmt_hit && nmt_cmd == NMT_RNODE |=> s_app_path)
    else $error("reset node path broken");
  a_reset_comm: assert property (@(posedge clk) disable iff (reset) // R7
    nmt_hit && nmt_cmd == NMT_RCOMM |=> state == ST_RCOM ##1 state == ST_INIT)
    else $error("reset communication path broken");
  a_pdo_in_op: assert property (@(posedge clk) disable iff (reset) // R8
    $rose(tx_valid) && tx_is_pdo |-> $past(state) == ST_OP)
    else $error("process data sent outside operational");
  a_emcy_cause: assert property (@(posedge clk) disable iff (reset) // R20
    $rose(tx_valid) && tx_id == cob_of(COB_EMCY, 2'h0) |-> $past(emcy_pend))
    else $error("emergency sent without a fault");
  a_type_reject: assert property (@(posedge clk) disable iff (reset) // R23
    sdo_hit && ccs == CCS_DL && rx_data[SDO_EXP_BIT] && is_tcfg && !od_req && !sdo_pend
    && !cop_tt_ok(rx_data[39:32]) |=> sdo_pend && sdo_resp[7:0] == SCS_ABT)
    else $error("reserved transmission type not aborted");
endmodule : cop_node

/* hdl/cop_pkg.sv */
// Constants, types and helpers shared by the protocol node and its PDO channels.
// Behaviour
// R1 - Power-up enters initialization without any command
// R2 - Boot-up sent in init, then pre-operational
// R3 - Start command moves to operational
// R4 - Enter-pre-operational command returns to pre-operational
// R5 - Stop command moves to stopped
// R6 - Reset node: reset-application, then reset-communication
// R7 - Reset communication re-initializes communication state
// R8 - Services gated by the current network state
// R9 - Time-stamp frames are ignored entirely
// R10 - Over four bytes needs segments with end; the node aborts every non-expedited download with AB_LEN instead
// R11 - SDO uses separate request and response identifiers
// R12 - Serve initiate download, initiate upload, abort
// R13 - Four PDO channels, sent without confirmation
// R14 - Types 1-240 send every N syncs
// R15 - Type 252 refreshes on sync, sends on request
// R16 - Type 253 refreshes when remote request arrives
// R17 - Type 254 is never accepted
// R18 - Type 255 sends on local events
// R19 - PDO carries only mapped object data
// R20 - Emergency sent only on internal hardware fault
// R21 - Default identifiers; SYNC and emergency supported
// R22 - Exactly one network master commands all nodes
// R23 - Reserved transmission type write answered by abort
package cop_pkg;
  localparam int NCH = 4;
  localparam logic [10:0] COB_NMT = 11'h000;
  localparam logic [10:0] COB_SYNC = 11'h080;
  localparam logic [10:0] COB_EMCY = 11'h080;
  localparam logic [10:0] COB_TIME = 11'h100;
  localparam logic [10:0] COB_TPDO = 11'h180;
  localparam logic [10:0] COB_RPDO = 11'h200;
  localparam logic [10:0] COB_SDO_TX = 11'h580;
  localparam logic [10:0] COB_SDO_RX = 11'h600;
  localparam logic [10:0] COB_BOOT = 11'h700;
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_STOP = 8'h02;
  localparam logic [7:0] NMT_PREOP = 8'h80;
  localparam logic [7:0] NMT_RNODE = 8'h81;
  localparam logic [7:0] NMT_RCOMM = 8'h82;
  localparam logic [7:0] NMT_ALL = 8'h00;
  localparam logic [7:0] BOOT_BYTE = 8'h00;
  localparam logic [7:0] EMCY_ERR_REG = 8'h01;
  localparam logic [2:0] CCS_DL = 3'h1;
  localparam logic [2:0] CCS_UL = 3'h2;
  localparam logic [2:0] CCS_ABT = 3'h4;
  localparam int SDO_EXP_BIT = 1;
  localparam logic [7:0] SCS_DL_RSP = 8'h60;
  localparam logic [7:0] SCS_UL_RSP = 8'h43;
  localparam logic [7:0] SCS_ABT = 8'h80;
  localparam logic [31:0] AB_CMD = 32'h05040001;
  localparam logic [31:0] AB_LEN = 32'h06070012;
  localparam logic [31:0] AB_RANGE = 32'h06090030;
  localparam logic [31:0] AB_OD = 32'h08000000;
  localparam logic [15:0] IDX_TPDO_COMM = 16'h1800;
  localparam logic [7:0] SUB_TTYPE = 8'h02;
  localparam logic [7:0] TT_ACYC = 8'h00;
  localparam logic [7:0] TT_SYNC_MIN = 8'h01;
  localparam logic [7:0] TT_SYNC_MAX = 8'hf0;
  localparam logic [7:0] TT_RTR_SYNC = 8'hfc;
  localparam logic [7:0] TT_RTR = 8'hfd;
  localparam logic [7:0] TT_EV_MFR = 8'hfe;
  localparam logic [7:0] TT_EV = 8'hff;
  localparam logic [3:0] DLC_BOOT = 4'h1;
  localparam logic [3:0] DLC_PDO = 4'h4;
  localparam logic [3:0] DLC_FULL = 4'h8;

  typedef enum logic [5:0] {
    ST_INIT = 6'b000001,
    ST_PREOP = 6'b000010,
    ST_OP = 6'b000100,
    ST_STOP = 6'b001000,
    ST_RAPP = 6'b010000,
    ST_RCOM = 6'b100000
  } cop_nmt_t;

  // Reserved codes and the unsupported event type are refused at configuration.
  function automatic logic cop_tt_ok(input logic [7:0] tt);
    return (tt <= TT_SYNC_MAX) || (tt == TT_RTR_SYNC) || (tt == TT_RTR) || (tt == TT_EV); // R17 R23
  endfunction : cop_tt_ok
endpackage : cop_pkg

/* hdl/cop_tpdo.sv */
// One transmit PDO channel: trigger logic, sync counter and data snapshot.
`timescale 1ns/1ps
module cop_tpdo (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Triggers
  input wire logic op,
  input wire logic sync,
  input wire logic rtr,
  input wire logic event_in,
  input wire logic grant,
  input wire logic comm_clr,
  // Configuration
  input wire logic cfg_we,
  input wire logic [7:0] cfg_type,
  // Mapped object value
  input wire logic [31:0] map_data,
  // Channel state
  output logic [7:0] ttype,
  output logic pend,
  output logic [31:0] snap
);
  import cop_pkg::*;

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] inc;
  logic [7:0] next_ttype;
  logic evt;
  logic next_evt;
  logic next_pend;
  logic [31:0] next_snap;

  assign inc = cnt + TT_SYNC_MIN;

  always_comb begin
    next_ttype = ttype;
    next_cnt = cnt;
    next_evt = evt;
    next_pend = pend;
    next_snap = snap;
    if (grant) begin
      next_pend = 1'b0;
    end
    if (cfg_we) begin
      next_ttype = cfg_type;
    end
    if (!op) begin
      next_pend = 1'b0;
      next_cnt = '0;
      next_evt = 1'b0;
    end else begin
      if (sync) begin
        if (ttype == TT_ACYC) begin
          if (evt) begin
            next_snap = map_data; // R19
            next_pend = 1'b1;
            next_evt = 1'b0;
          end
        end else if (ttype <= TT_SYNC_MAX) begin
          if (inc >= ttype) begin
            next_snap = map_data; // R14
            next_pend = 1'b1;
            next_cnt = '0;
          end else begin
            next_cnt = inc;
          end
        end else if (ttype == TT_RTR_SYNC) begin
          next_snap = map_data; // R15
        end
      end
      // Set wins over the grant of the same cycle, so no trigger is lost.
      if (rtr) begin
        if (ttype == TT_RTR_SYNC) begin
          next_pend = 1'b1; // R15
        end else if (ttype == TT_RTR) begin
          next_snap = map_data; // R16
          next_pend = 1'b1;
        end
      end
      if (event_in) begin
        if (ttype == TT_EV) begin
          next_snap = map_data; // R18
          next_pend = 1'b1;
        end else if (ttype == TT_ACYC) begin
          next_evt = 1'b1;
        end
      end
    end
    if (comm_clr) begin
      next_ttype = TT_EV;
      next_cnt = '0;
      next_evt = 1'b0;
      next_pend = 1'b0;
      next_snap = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ttype <= TT_EV;
      cnt <= '0;
      evt <= 1'b0;
      pend <= 1'b0;
      snap <= '0;
    end else begin
      ttype <= next_ttype;
      cnt <= next_cnt;
      evt <= next_evt;
      pend <= next_pend;
      snap <= next_snap;
    end
  end

  a_sync_period: assert property (@(posedge clk) disable iff (reset) // R14
    $rose(pend) && $past(ttype) >= TT_SYNC_MIN && $past(ttype) <= TT_SYNC_MAX |-> $past(sync))
    else $error("sync channel raised a request without a sync");
  a_rtr_refresh: assert property (@(posedge clk) disable iff (reset) // R16
    op && rtr && ttype == TT_RTR && !comm_clr && !cfg_we |=> pend && snap == $past(map_data))
    else $error("remote request did not refresh the channel");
  a_sync_no_send: assert property (@(posedge clk) disable iff (reset) // R15
    sync && !rtr && !pend && ttype == TT_RTR_SYNC |=> !pend)
    else $error("sync alone started a remote-only channel");
endmodule : cop_tpdo

/* verification/cop_net_model.sv */
// Network-side model: takes the frames that the node offers, stalling when told to.
`timescale 1ns/1ps
module cop_net_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Frames from the node
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data,
  // Stall control and the last frame taken
  input wire logic stall,
  output logic got,
  output logic [74:0] frame
);
  assign tx_ready = !stall;
  // Frames are taken without any confirmation back to the node.
  always_ff @(posedge clk) begin
    got <= !reset && tx_valid && tx_ready;
    if (tx_valid && tx_ready) begin
      frame <= {tx_id, tx_dlc, tx_data};
    end
  end
endmodule : cop_net_model

/* verification/cop_node_bench.sv */
// Self-checking bench for the slave node protocol layer.
`timescale 1ns/1ps
module cop_node_bench;
  import cop_pkg::*;
  localparam logic [6:0] NID = 7'h05;
  localparam logic [10:0] N11 = {4'h0, NID};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rx_valid = 1'b0;
  logic [10:0] rx_id = 11'h000;
  logic rx_rtr = 1'b0;
  logic [63:0] rx_data = 64'h0;
  logic od_ack = 1'b0;
  logic [31:0] od_rdata = 32'h0;
  logic [127:0] tpdo_map = 128'h0;
  logic [3:0] tpdo_event = 4'h0;
  logic hw_fault = 1'b0;
  logic [15:0] fault_code = 16'h0;
  logic stall = 1'b0;
  logic tx_valid, tx_ready, od_req, rpdo_valid, app_reset, got;
  logic [10:0] tx_id;
  logic [3:0] tx_dlc;
  logic [63:0] tx_data, rpdo_data;
  logic [1:0] rpdo_chan;
  logic [74:0] frame;
  logic [31:0] r;
  logic [127:0] m;
  logic [15:0] idx;
  logic [7:0] cfg [4] = '{8'h03, TT_EV, TT_RTR, TT_RTR_SYNC};
  cop_nmt_t state;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h4ea629c2;

  cop_node #(.NODE_ID(NID)) u_cop_node (
    .clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr),
    .rx_dlc(4'h8), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .od_req(od_req), .od_wr(),
    .od_index(), .od_sub(), .od_wdata(), .od_ack(od_ack), .od_err(1'b0),
    .od_rdata(od_rdata), .tpdo_map(tpdo_map), .tpdo_event(tpdo_event),
    .rpdo_valid(rpdo_valid), .rpdo_chan(rpdo_chan), .rpdo_data(rpdo_data),
    .hw_fault(hw_fault), .fault_code(fault_code), .state(state), .app_reset(app_reset));
  cop_net_model u_cop_net_model (
    .clk(clk), .reset(reset), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
    .tx_dlc(tx_dlc), .tx_data(tx_data), .stall(stall), .got(got), .frame(frame));

  always #12.5 clk = ~clk;

  // Fixed cadences keep the stall and acknowledge pattern apart from the random stream.
  always @(negedge clk) begin
    stall <= (cycles % 4 == 1);
    od_ack <= od_req && !od_ack && (cycles % 3 == 0);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_frame(input string nm, input logic [74:0] exp, input logic [74:0] act);
    n_checks++;
    if (act !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, act);
    end
  endtask : chk_frame

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] act);
    n_checks++;
    if (act !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, act);
    end
  endtask : chk_val

  function automatic logic [74:0] fr(input logic [10:0] id, input logic [3:0] n,
                                     input logic [63:0] d);
    return {id + N11, n, d};
  endfunction : fr

  function automatic logic [63:0] sdo(input logic [7:0] c, input logic [15:0] ix,
                                      input logic [7:0] sb, input logic [31:0] v);
    return {v, sb, ix, c};
  endfunction : sdo

  function automatic logic [63:0] tt_rsp(input logic [15:0] ix, input logic [7:0] t);
    if ((t > 8'hf0 && t < 8'hfc) || t == 8'hfe) begin
      return sdo(SCS_ABT, ix, SUB_TTYPE, AB_RANGE);
    end
    return sdo(SCS_DL_RSP, ix, SUB_TTYPE, 32'h0);
  endfunction : tt_rsp

  task automatic send(input logic [10:0] id, input logic rtr, input logic [63:0] d);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_id = id;
    rx_rtr = rtr;
    rx_data = d;
    @(negedge clk);
    rx_valid = 1'b0;
  endtask : send

  task automatic expect_frame(input string nm, input logic [74:0] exp);
    int n;
    n = 0;
    while (got !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk_frame(nm, exp, got === 1'b1 ? frame : 75'h0);
    @(negedge clk);
  endtask : expect_frame

  task automatic quiet(input string nm, input int n);
    repeat (n) begin
      @(negedge clk);
      chk_val(nm, 32'h0, {31'h0, got});
    end
  endtask : quiet

  task automatic nmt(input logic [7:0] c, input cop_nmt_t st);
    send(COB_NMT, 1'b0, {48'h0, 1'b0, NID, c});
    chk_val("state", 32'(st), 32'(state));
  endtask : nmt

  task automatic sdo_x(input logic [63:0] q, input logic [63:0] a);
    send(COB_SDO_RX + N11, 1'b0, q);
    expect_frame("sdo", fr(COB_SDO_TX, DLC_FULL, a));
  endtask : sdo_x

  task automatic pulse_ev(input logic [3:0] e);
    @(negedge clk);
    tpdo_event = e;
    @(negedge clk);
    tpdo_event = 4'h0;
  endtask : pulse_ev

  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    expect_frame("boot", fr(COB_BOOT, DLC_BOOT, 64'h0));
    chk_val("state", 32'(ST_PREOP), 32'(state));
    send(COB_TIME, 1'b0, {$random(seed), $random(seed)});
    quiet("time", 4);
    for (int k = 0; k < 4; k++) begin
      idx = 16'h1800 + 16'(k);
      r = $random(seed);
      sdo_x(sdo(8'h23, idx, SUB_TTYPE, r), tt_rsp(idx, r[7:0]));
      sdo_x(sdo(8'h23, idx, SUB_TTYPE, {24'h0, TT_EV_MFR}), tt_rsp(idx, TT_EV_MFR));
      sdo_x(sdo(8'h23, idx, SUB_TTYPE, {24'h0, cfg[k]}), tt_rsp(idx, cfg[k]));
      sdo_x(sdo(8'h40, idx, SUB_TTYPE, 32'h0), sdo(SCS_UL_RSP, idx, SUB_TTYPE, {24'h0, cfg[k]}));
    end
    sdo_x(sdo(8'h21, 16'h2000, 8'h00, r), sdo(SCS_ABT, 16'h2000, 8'h00, AB_LEN));
    od_rdata = $random(seed);
    sdo_x(sdo(8'h23, 16'h2000, 8'h01, r), sdo(SCS_DL_RSP, 16'h2000, 8'h01, 32'h0));
    sdo_x(sdo(8'h40, 16'h2000, 8'h01, 32'h0), sdo(SCS_UL_RSP, 16'h2000, 8'h01, od_rdata));
    nmt(NMT_START, ST_OP);
    tpdo_map = {$random(seed), $random(seed), $random(seed), $random(seed)};
    pulse_ev(4'h2);
    expect_frame("event", fr(COB_TPDO + 11'h100, DLC_PDO, {32'h0, tpdo_map[63:32]}));
    repeat (2) send(COB_SYNC, 1'b0, 64'h0);
    quiet("sync", 4);
    m = tpdo_map;
    send(COB_SYNC, 1'b0, 64'h0);
    tpdo_map = ~m;
    expect_frame("sync", fr(COB_TPDO, DLC_PDO, {32'h0, m[31:0]}));
    send(COB_TPDO + 11'h300 + N11, 1'b1, 64'h0);
    expect_frame("rtr", fr(COB_TPDO + 11'h300, DLC_PDO, {32'h0, m[127:96]}));
    send(COB_TPDO + 11'h200 + N11, 1'b1, 64'h0);
    expect_frame("rtr", fr(COB_TPDO + 11'h200, DLC_PDO, {32'h0, ~m[95:64]}));
    send(COB_RPDO + 11'h100 + N11, 1'b0, {m[31:0], m[63:32]});
    chk_val("rpdo", 32'h5, {29'h0, rpdo_valid, rpdo_chan});
    chk_val("rpdo", m[63:32], rpdo_data[31:0]);
    r = $random(seed);
    @(negedge clk);
    hw_fault = 1'b1;
    fault_code = r[15:0];
    @(negedge clk);
    hw_fault = 1'b0;
    expect_frame("emcy", fr(COB_EMCY, DLC_FULL, {40'h0, EMCY_ERR_REG, r[15:0]}));
    nmt(NMT_STOP, ST_STOP);
    send(COB_SYNC, 1'b0, 64'h0);
    pulse_ev(4'h2);
    quiet("stop", 6);
    nmt(NMT_START, ST_OP);
    nmt(NMT_PREOP, ST_PREOP);
    nmt(NMT_RCOMM, ST_RCOM);
    expect_frame("boot", fr(COB_BOOT, DLC_BOOT, 64'h0));
    sdo_x(sdo(8'h40, idx, SUB_TTYPE, 32'h0), sdo(SCS_UL_RSP, idx, SUB_TTYPE, {24'h0, TT_EV}));
    nmt(NMT_RNODE, ST_RAPP);
    chk_val("app_reset", 32'h1, {31'h0, app_reset});
    expect_frame("boot", fr(COB_BOOT, DLC_BOOT, 64'h0));
    chk_val("state", 32'(ST_PREOP), 32'(state));
    print_verdict();
  end
endmodule : cop_node_bench
